//--- hdl/tas_timer16.sv
// 16-bit timer with shared high-byte register access and prescaler sync control

// How it works
// - Sync mode holds written prescaler reset bits
// - Writing zero to sync control clears both resets
// - Timer-1 prescaler reset self-clears unless sync
// - Four flags: overflow, match A/B, capture
// - Two compare channels, four pins each
// - Flags visible, each request gated by mask bit
// - No clock source selected halts the counter
// - Buffered compares checked on each timer tick, set flags
// - Capture latches counter on filtered pin edge
// - Ceiling A in PWM: no A output, buffered
// - Floor flagged when counter is 0x0000
// - Maximum flagged when counter is 0xFFFF
// - Ceiling fixed 0xFF/0x1FF/0x3FF/0xFFFF or register
// - One shared 8-bit temporary high byte
// - Low-byte write loads temp and low together
// - Low-byte read copies high into temp
// - Compare reads bypass the temporary byte
// - Control registers are plain 8-bit access
module tas_timer16 #(
  parameter int PRESC_W    = 10,  // Prescaler width, taps reach divide by 1024
  parameter int FILTER_LEN = 4    // Samples that must agree in the noise filter
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire tas_pkg::tas_io_req_type io_req,
  output logic [7:0]                   io_rdata,
  input  wire logic [3:0]              irq_ack,
  output logic [3:0]                   irq_req,
  input  wire logic                    external_count_pin,
  input  wire logic                    capture_input_pin,
  input  wire logic                    comparator_out,
  output logic [3:0]                   oc_pins_a,
  output logic [3:0]                   oc_pins_b,
  output logic                         prescaler_reset_t0,
  output logic                         prescaler_reset_t1,
  output logic                         count_at_floor,
  output logic                         count_at_max
);

  // Parameters the taps and filter cannot serve are refused
  if (PRESC_W < 10 || FILTER_LEN < 2 || FILTER_LEN > 16)
  begin : g_bad_param
    $error("tas_timer16: PRESC_W must be >= 10 and FILTER_LEN within 2..16");
  end

  // Mode is PWM (buffered compares, clear-to-floor waveform)
  function automatic logic is_pwm(input logic [3:0] wgm);
    is_pwm = (wgm[1:0] != 2'b00) && (wgm != 4'hD);
  endfunction

  // Capture register is the ceiling, so the capture input is ignored
  function automatic logic cap_is_top(input logic [3:0] wgm);
    cap_is_top = (wgm == tas_pkg::WGM_CTC_C) || (wgm == tas_pkg::WGM_PWM_C);
  endfunction

  // Synchronised pins: bit 0 count pin, bit 1 capture pin, bit 2 comparator
  logic [2:0] pin_lvl;
  logic [2:0] pin_prev;

  tas_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk        (clk),
    .srst       (srst),
    .pin_in     ({comparator_out, capture_input_pin, external_count_pin}),
    .level      (pin_lvl),
    .level_prev (pin_prev)
  );

  // Register state
  logic [7:0]         sync_ctl_ff,  nxt_sync_ctl;   // timer_sync_control
  logic [7:0]         ctrl_a_ff,    nxt_ctrl_a;     // timer_control_a
  logic [7:0]         ctrl_b_ff,    nxt_ctrl_b;     // timer_control_b
  logic [7:0]         mask_ff,      nxt_mask;       // timer_mask_reg
  logic [7:0]         out_en_ff,    nxt_out_en;     // Output pin enables
  logic [3:0]         flag_ff,      nxt_flag;       // timer_flag_reg bits
  logic [15:0]        cnt_ff,       nxt_cnt;        // counter_value
  logic [15:0]        cmpa_buf_ff,  nxt_cmpa_buf;   // CPU-visible compare A
  logic [15:0]        cmpb_buf_ff,  nxt_cmpb_buf;   // CPU-visible compare B
  logic [15:0]        cmpa_act_ff,  nxt_cmpa_act;   // Compare A in use
  logic [15:0]        cmpb_act_ff,  nxt_cmpb_act;   // Compare B in use
  logic [15:0]        cap_ff,       nxt_cap;        // capture_value
  logic [7:0]         temp_ff,      nxt_temp;       // Shared high-byte temporary
  logic [7:0]         rdata_ff,     nxt_rdata;      // Registered read data
  logic [PRESC_W-1:0] presc_ff,     nxt_presc;      // Free-running prescaler
  logic [FILTER_LEN-1:0] filt_sh_ff, nxt_filt_sh;   // Filter sample history
  logic               filt_lvl_ff,  nxt_filt_lvl;   // Filtered capture level
  logic               filt_prev_ff, nxt_filt_prev;  // Previous filtered level

  // Output state
  logic       wave_a_ff, nxt_wave_a;
  logic       wave_b_ff, nxt_wave_b;
  logic [3:0] pins_a_ff, nxt_pins_a;
  logic [3:0] pins_b_ff, nxt_pins_b;
  logic [3:0] irq_ff,    nxt_irq;
  logic       floor_ff,  nxt_floor;
  logic       max_ff,    nxt_max;

  // Decoded controls
  logic [3:0]  wgm;
  logic [2:0]  cs;
  logic [15:0] top;
  logic        tick;
  logic        halted;
  logic        wrap;
  logic        match_a;
  logic        match_b;
  logic        cap_edge;
  logic        wr_sync;
  logic        wr_flag;
  logic [1:0]  wgm_lo;
  logic        cap_src;

  assign wgm     = {ctrl_b_ff[tas_pkg::WGM_HI_LSB +: 2], ctrl_a_ff[1:0]};
  assign cs      = ctrl_b_ff[tas_pkg::CS_LSB +: 3];
  assign wgm_lo  = wgm[1:0];
  assign cap_src = ctrl_b_ff[tas_pkg::CAP_SRC_BIT];
  assign wr_sync = io_req.wr && (io_req.addr == tas_pkg::ADDR_SYNC);
  assign wr_flag = io_req.wr && (io_req.addr == tas_pkg::ADDR_FLAG);

  // Prescaler: held at zero while its reset bit is one
  always_comb
  begin
    if (sync_ctl_ff[tas_pkg::PSR_T1_BIT])
      nxt_presc = '0;
    else
      nxt_presc = presc_ff + PRESC_W'(1);
  end

  // Sync control: written reset bits stick only in sync mode
  always_comb
  begin
    nxt_sync_ctl = sync_ctl_ff;
    if (wr_sync)
    begin
      // Sync mode and both reset bits take the written value; writing sync
      // mode zero with both resets zero releases all counters in one cycle
      nxt_sync_ctl = io_req.wdata & 8'h83;
    end
    else if (!sync_ctl_ff[tas_pkg::SYNC_HOLD_BIT])
    begin
      // Reset bits self-clear one cycle after being written
      nxt_sync_ctl[tas_pkg::PSR_T1_BIT] = 1'b0;
      nxt_sync_ctl[tas_pkg::PSR_T0_BIT] = 1'b0;
    end
  end

  // Timer clock: stopped, system clock, prescaler tap or pin edge
  always_comb
  begin
    halted = sync_ctl_ff[tas_pkg::SYNC_HOLD_BIT] && sync_ctl_ff[tas_pkg::PSR_T1_BIT];
    unique case (cs)
      tas_pkg::CS_STOP:   tick = 1'b0;
      tas_pkg::CS_SYS:    tick = 1'b1;
      tas_pkg::CS_DIV8:   tick = &presc_ff[2:0];
      tas_pkg::CS_DIV64:  tick = &presc_ff[5:0];
      tas_pkg::CS_DIV256: tick = &presc_ff[7:0];
      tas_pkg::CS_DIV1K:  tick = &presc_ff[9:0];
      tas_pkg::CS_EXT_F:  tick = pin_prev[0] && !pin_lvl[0];
      tas_pkg::CS_EXT_R:  tick = !pin_prev[0] && pin_lvl[0];
    endcase
    if (halted || sync_ctl_ff[tas_pkg::PSR_T1_BIT] && cs != tas_pkg::CS_SYS
        && cs < tas_pkg::CS_EXT_F)
      tick = 1'b0;
  end

  // Ceiling selection by mode
  always_comb
  begin
    if (wgm == tas_pkg::WGM_CTC_A || wgm == tas_pkg::WGM_PWM_A)
      top = cmpa_act_ff;
    else if (cap_is_top(wgm))
      top = cap_ff;
    else if (is_pwm(wgm) && wgm_lo == 2'b01)
      top = tas_pkg::TOP_8BIT;
    else if (is_pwm(wgm) && wgm_lo == 2'b10)
      top = tas_pkg::TOP_9BIT;
    else if (is_pwm(wgm) && wgm_lo == 2'b11)
      top = tas_pkg::TOP_10BIT;
    else
      top = tas_pkg::COUNT_MAX;
  end

  assign wrap    = tick && (cnt_ff == top);
  assign match_a = tick && (cnt_ff == cmpa_act_ff);
  assign match_b = tick && (cnt_ff == cmpb_act_ff);

  // Capture source, noise filter and edge detection
  always_comb
  begin
    logic sample;
    sample        = cap_src ? pin_lvl[2] : pin_lvl[1];
    nxt_filt_sh   = {filt_sh_ff[FILTER_LEN-2:0], sample};
    nxt_filt_lvl  = filt_lvl_ff;
    if (!ctrl_b_ff[tas_pkg::CAP_NF_BIT])
      nxt_filt_lvl = sample;
    else if (&filt_sh_ff)
      nxt_filt_lvl = 1'b1;
    else if (~|filt_sh_ff)
      nxt_filt_lvl = 1'b0;
    nxt_filt_prev = filt_lvl_ff;
    cap_edge = (filt_lvl_ff != filt_prev_ff)
             && (filt_lvl_ff == ctrl_b_ff[tas_pkg::CAP_EDG_BIT]) && !cap_is_top(wgm);
  end

  // CPU access, counting, buffers, capture and flags
  always_comb
  begin
    nxt_ctrl_a   = ctrl_a_ff;
    nxt_ctrl_b   = ctrl_b_ff;
    nxt_mask     = mask_ff;
    nxt_out_en   = out_en_ff;
    nxt_cmpa_buf = cmpa_buf_ff;
    nxt_cmpb_buf = cmpb_buf_ff;
    nxt_cap      = cap_ff;
    nxt_temp     = temp_ff;
    nxt_rdata    = rdata_ff;
    // Counter advances on the timer clock and folds to the floor at the ceiling
    nxt_cnt = cnt_ff;
    if (wrap)
      nxt_cnt = tas_pkg::COUNT_FLOOR;
    else if (tick)
      nxt_cnt = cnt_ff + 16'h0001;
    // Capture snapshots the counter as it stands
    if (cap_edge)
      nxt_cap = cnt_ff;
    // Writes: control registers single access, 16-bit ones through temporary
    if (io_req.wr)
    begin
      unique case (io_req.addr)
        tas_pkg::ADDR_CTRL_A: nxt_ctrl_a = io_req.wdata;
        tas_pkg::ADDR_CTRL_B: nxt_ctrl_b = io_req.wdata;
        tas_pkg::ADDR_MASK:   nxt_mask   = io_req.wdata & tas_pkg::FLAG_MASK;
        tas_pkg::ADDR_OUT_EN: nxt_out_en = io_req.wdata;
        tas_pkg::ADDR_CNT_H, tas_pkg::ADDR_CAP_H,
        tas_pkg::ADDR_CMPA_H, tas_pkg::ADDR_CMPB_H:
          nxt_temp = io_req.wdata;
        // CPU write takes priority over counting
        tas_pkg::ADDR_CNT_L:  nxt_cnt = {temp_ff, io_req.wdata};
        tas_pkg::ADDR_CMPA_L: nxt_cmpa_buf = {temp_ff, io_req.wdata};
        tas_pkg::ADDR_CMPB_L: nxt_cmpb_buf = {temp_ff, io_req.wdata};
        // Capture register is only writable while it sets the ceiling
        tas_pkg::ADDR_CAP_L:
          if (cap_is_top(wgm))
            nxt_cap = {temp_ff, io_req.wdata};
        default: ;
      endcase
    end
    // Reads: low byte copies high into temporary, compares read directly
    if (io_req.rd)
    begin
      unique case (io_req.addr)
        tas_pkg::ADDR_SYNC:   nxt_rdata = sync_ctl_ff;
        tas_pkg::ADDR_CTRL_A: nxt_rdata = ctrl_a_ff;
        tas_pkg::ADDR_CTRL_B: nxt_rdata = ctrl_b_ff;
        tas_pkg::ADDR_FLAG:   nxt_rdata = {4'h0, flag_ff};
        tas_pkg::ADDR_MASK:   nxt_rdata = mask_ff;
        tas_pkg::ADDR_OUT_EN: nxt_rdata = out_en_ff;
        tas_pkg::ADDR_CNT_L:
        begin
          nxt_rdata = cnt_ff[7:0];
          nxt_temp  = cnt_ff[15:8];
        end
        tas_pkg::ADDR_CAP_L:
        begin
          nxt_rdata = cap_ff[7:0];
          nxt_temp  = cap_ff[15:8];
        end
        tas_pkg::ADDR_CNT_H, tas_pkg::ADDR_CAP_H: nxt_rdata = temp_ff;
        tas_pkg::ADDR_CMPA_L: nxt_rdata = cmpa_buf_ff[7:0];
        tas_pkg::ADDR_CMPA_H: nxt_rdata = cmpa_buf_ff[15:8];
        tas_pkg::ADDR_CMPB_L: nxt_rdata = cmpb_buf_ff[7:0];
        tas_pkg::ADDR_CMPB_H: nxt_rdata = cmpb_buf_ff[15:8];
        default:              nxt_rdata = tas_pkg::RST_BYTE;
      endcase
    end
    // Compares in use: direct in non-PWM, loaded at the ceiling in PWM so a
    // period never sees a half-updated ceiling or threshold
    nxt_cmpa_act = cmpa_act_ff;
    nxt_cmpb_act = cmpb_act_ff;
    if (!is_pwm(wgm) || wrap)
    begin
      nxt_cmpa_act = nxt_cmpa_buf;
      nxt_cmpb_act = nxt_cmpb_buf;
    end
    // Flags: hardware set wins over write-one or acknowledge clear
    nxt_flag = flag_ff & ~irq_ack;
    if (wr_flag)
      nxt_flag = nxt_flag & ~io_req.wdata[3:0];
    nxt_flag[tas_pkg::FLG_OVF] = nxt_flag[tas_pkg::FLG_OVF] | wrap;
    nxt_flag[tas_pkg::FLG_MA]  = nxt_flag[tas_pkg::FLG_MA] | match_a;
    nxt_flag[tas_pkg::FLG_MB]  = nxt_flag[tas_pkg::FLG_MB] | match_b;
    nxt_flag[tas_pkg::FLG_CAP] = nxt_flag[tas_pkg::FLG_CAP] | cap_edge;
  end

  // Waveforms, pins, requests and boundary status
  always_comb
  begin
    nxt_wave_a = wave_a_ff;
    nxt_wave_b = wave_b_ff;
    if (is_pwm(wgm))
    begin
      if (wrap)
      begin
        nxt_wave_a = 1'b1;
        nxt_wave_b = 1'b1;
      end
      if (match_a)
        nxt_wave_a = 1'b0;
      if (match_b)
        nxt_wave_b = 1'b0;
    end
    else
    begin
      nxt_wave_a = wave_a_ff ^ match_a;
      nxt_wave_b = wave_b_ff ^ match_b;
    end
    // Channel A cannot drive PWM while it holds the ceiling
    if (wgm == tas_pkg::WGM_PWM_A)
      nxt_pins_a = 4'h0;
    else
      nxt_pins_a = {4{wave_a_ff}} & out_en_ff[3:0];
    nxt_pins_b = {4{wave_b_ff}} & out_en_ff[7:4];
    nxt_irq    = flag_ff & mask_ff[3:0];
    nxt_floor  = (cnt_ff == tas_pkg::COUNT_FLOOR);
    nxt_max    = (cnt_ff == tas_pkg::COUNT_MAX);
  end

  // Register all state
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync_ctl_ff  <= tas_pkg::RST_BYTE;
      ctrl_a_ff    <= tas_pkg::RST_BYTE;
      ctrl_b_ff    <= tas_pkg::RST_BYTE;
      mask_ff      <= tas_pkg::RST_BYTE;
      out_en_ff    <= tas_pkg::RST_BYTE;
      flag_ff      <= 4'h0;
      cnt_ff       <= tas_pkg::RST_WORD;
      cmpa_buf_ff  <= tas_pkg::RST_WORD;
      cmpb_buf_ff  <= tas_pkg::RST_WORD;
      cmpa_act_ff  <= tas_pkg::RST_WORD;
      cmpb_act_ff  <= tas_pkg::RST_WORD;
      cap_ff       <= tas_pkg::RST_WORD;
      temp_ff      <= tas_pkg::RST_BYTE;
      rdata_ff     <= tas_pkg::RST_BYTE;
      presc_ff     <= '0;
      filt_sh_ff   <= '0;
      filt_lvl_ff  <= 1'b0;
      filt_prev_ff <= 1'b0;
      wave_a_ff    <= 1'b0;
      wave_b_ff    <= 1'b0;
      pins_a_ff    <= 4'h0;
      pins_b_ff    <= 4'h0;
      irq_ff       <= 4'h0;
      floor_ff     <= 1'b0;
      max_ff       <= 1'b0;
    end
    else
    begin
      sync_ctl_ff  <= nxt_sync_ctl;
      ctrl_a_ff    <= nxt_ctrl_a;
      ctrl_b_ff    <= nxt_ctrl_b;
      mask_ff      <= nxt_mask;
      out_en_ff    <= nxt_out_en;
      flag_ff      <= nxt_flag;
      cnt_ff       <= nxt_cnt;
      cmpa_buf_ff  <= nxt_cmpa_buf;
      cmpb_buf_ff  <= nxt_cmpb_buf;
      cmpa_act_ff  <= nxt_cmpa_act;
      cmpb_act_ff  <= nxt_cmpb_act;
      cap_ff       <= nxt_cap;
      temp_ff      <= nxt_temp;
      rdata_ff     <= nxt_rdata;
      presc_ff     <= nxt_presc;
      filt_sh_ff   <= nxt_filt_sh;
      filt_lvl_ff  <= nxt_filt_lvl;
      filt_prev_ff <= nxt_filt_prev;
      wave_a_ff    <= nxt_wave_a;
      wave_b_ff    <= nxt_wave_b;
      pins_a_ff    <= nxt_pins_a;
      pins_b_ff    <= nxt_pins_b;
      irq_ff       <= nxt_irq;
      floor_ff     <= nxt_floor;
      max_ff       <= nxt_max;
    end
  end

  // Outputs straight from flip-flops
  assign io_rdata           = rdata_ff;
  assign irq_req            = irq_ff;
  assign oc_pins_a          = pins_a_ff;
  assign oc_pins_b          = pins_b_ff;
  assign prescaler_reset_t0 = sync_ctl_ff[tas_pkg::PSR_T0_BIT];
  assign prescaler_reset_t1 = sync_ctl_ff[tas_pkg::PSR_T1_BIT];
  assign count_at_floor     = floor_ff;
  assign count_at_max       = max_ff;

endmodule

//--- hdl/tas_pkg.sv
// Shared constants and carrier types for the 16-bit timer access and sync front end
package tas_pkg;

  // Register addresses on the 8-bit internal I/O bus
  localparam logic [7:0] ADDR_SYNC   = 8'h00;  // timer_sync_control
  localparam logic [7:0] ADDR_CTRL_A = 8'h01;  // timer_control_a
  localparam logic [7:0] ADDR_CTRL_B = 8'h02;  // timer_control_b
  localparam logic [7:0] ADDR_FLAG   = 8'h03;  // timer_flag_reg
  localparam logic [7:0] ADDR_MASK   = 8'h04;  // timer_mask_reg
  localparam logic [7:0] ADDR_OUT_EN = 8'h05;  // Output pin enables, A low nibble, B high
  localparam logic [7:0] ADDR_CNT_L  = 8'h06;  // counter_value low byte
  localparam logic [7:0] ADDR_CNT_H  = 8'h07;  // counter_value high byte (via temporary)
  localparam logic [7:0] ADDR_CAP_L  = 8'h08;  // capture_value low byte
  localparam logic [7:0] ADDR_CAP_H  = 8'h09;  // capture_value high byte (via temporary)
  localparam logic [7:0] ADDR_CMPA_L = 8'h0A;  // compare_value_a low byte
  localparam logic [7:0] ADDR_CMPA_H = 8'h0B;  // compare_value_a high byte
  localparam logic [7:0] ADDR_CMPB_L = 8'h0C;  // compare_value_b low byte
  localparam logic [7:0] ADDR_CMPB_H = 8'h0D;  // compare_value_b high byte

  // timer_sync_control field positions
  localparam int SYNC_HOLD_BIT = 7;  // sync_hold_mode
  localparam int PSR_T0_BIT    = 1;  // prescaler_reset_t0
  localparam int PSR_T1_BIT    = 0;  // prescaler_reset_t1

  // timer_control_b field positions
  localparam int CS_LSB      = 0;  // Clock select, 3 bits
  localparam int WGM_HI_LSB  = 3;  // Mode bits 3:2
  localparam int CAP_SRC_BIT = 5;  // 1: capture from comparator output
  localparam int CAP_EDG_BIT = 6;  // 1: capture on rising edge
  localparam int CAP_NF_BIT  = 7;  // 1: noise filter on

  // Flag and mask bit positions
  localparam int FLG_OVF = 0;  // overflow_flag
  localparam int FLG_MA  = 1;  // match_flag_a
  localparam int FLG_MB  = 2;  // match_flag_b
  localparam int FLG_CAP = 3;  // capture_flag
  localparam logic [7:0] FLAG_MASK = 8'h0F;  // Implemented flag bits

  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Count boundaries
  localparam logic [15:0] COUNT_FLOOR = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT    = 16'h00FF;
  localparam logic [15:0] TOP_9BIT    = 16'h01FF;
  localparam logic [15:0] TOP_10BIT   = 16'h03FF;

  // Mode codes with a register-defined ceiling
  localparam logic [3:0] WGM_CTC_A  = 4'h4;
  localparam logic [3:0] WGM_CTC_C  = 4'hC;
  localparam logic [3:0] WGM_PWM_C  = 4'hE;
  localparam logic [3:0] WGM_PWM_A  = 4'hF;

  // Clock select codes
  localparam logic [2:0] CS_STOP  = 3'h0;
  localparam logic [2:0] CS_SYS   = 3'h1;
  localparam logic [2:0] CS_DIV8  = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K = 3'h5;
  localparam logic [2:0] CS_EXT_F = 3'h6;
  localparam logic [2:0] CS_EXT_R = 3'h7;

  // One CPU access on the internal I/O bus
  typedef struct packed {
    logic [7:0] addr;   // Register address
    logic       wr;     // Write strobe, one cycle
    logic       rd;     // Read strobe, one cycle
    logic [7:0] wdata;  // Write data
  } tas_io_req_type;

endpackage

//--- hdl/tas_pin_sync.sv
// Two-stage synchroniser with one extra stage for edge detection
module tas_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] level_prev
);

  logic [WIDTH-1:0] meta_ff;   // First stage, read only by the second
  logic [WIDTH-1:0] sync_ff;   // Second stage, safe to use
  logic [WIDTH-1:0] prev_ff;   // Delayed copy for edge detection
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;
  logic [WIDTH-1:0] nxt_prev;

  // Shift chain
  always_comb
  begin
    nxt_meta = pin_in;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  // Register stages
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  assign level      = sync_ff;
  assign level_prev = prev_ff;

endmodule

//--- test/tas_timer16_props.sv
// Port-level checks of the timer access and sync front end
module tas_timer16_props (
  input wire logic                    clk,
  input wire logic                    srst,
  input wire tas_pkg::tas_io_req_type io_req,
  input wire logic [7:0]              io_rdata,
  input wire logic [3:0]              irq_req,
  input wire logic                    prescaler_reset_t0,
  input wire logic                    prescaler_reset_t1,
  input wire logic                    count_at_floor,
  input wire logic                    count_at_max
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Byte write or read aimed at one address
  function automatic logic wr_at(input logic [7:0] a);
    return io_req.wr && io_req.addr == a;
  endfunction
  function automatic logic rd_at(input logic [7:0] a);
    return io_req.rd && io_req.addr == a;
  endfunction
  // Counter word written high byte first, both bytes equal
  sequence s_cnt16(logic [7:0] d);
    wr_at(tas_pkg::ADDR_CNT_H) && io_req.wdata == d ##1
    wr_at(tas_pkg::ADDR_CNT_L) && io_req.wdata == d;
  endsequence
  // Sync write followed by a quiet cycle on that register
  sequence s_sync(logic [7:0] d);
    wr_at(tas_pkg::ADDR_SYNC) && io_req.wdata == d ##1 !wr_at(tas_pkg::ADDR_SYNC);
  endsequence
  a_sync_hold: assert property (s_sync(8'h83) |=> prescaler_reset_t0 && prescaler_reset_t1)
    else $error("prescaler resets not held in sync mode");
  a_sync_release: assert property (wr_at(tas_pkg::ADDR_SYNC) && io_req.wdata == 8'h00
    |=> !prescaler_reset_t0 && !prescaler_reset_t1) else $error("sync release left resets");
  a_t1_selfclr: assert property (s_sync(8'h01) |-> prescaler_reset_t1 ##1 !prescaler_reset_t1)
    else $error("timer-1 prescaler reset did not self clear");
  a_reset_quiet: assert property ($fell(srst) |-> irq_req == 4'h0 && !prescaler_reset_t0
    && !prescaler_reset_t1) else $error("outputs not idle after reset");
  a_floor_flag: assert property (s_cnt16(8'h00) |=> ##1 count_at_floor)
    else $error("floor not flagged");
  a_max_flag: assert property (s_cnt16(8'hFF) |=> ##1 count_at_max)
    else $error("maximum not flagged");
  a_cmp_direct: assert property (wr_at(tas_pkg::ADDR_CMPA_H) ##1 wr_at(tas_pkg::ADDR_CMPA_L)
    ##1 rd_at(tas_pkg::ADDR_CMPA_H) |=> io_rdata == $past(io_req.wdata, 3))
    else $error("compare high byte not read directly");
  a_ctrl_plain: assert property (wr_at(tas_pkg::ADDR_CTRL_B) ##1 rd_at(tas_pkg::ADDR_CTRL_B)
    |=> io_rdata == $past(io_req.wdata, 2)) else $error("control byte readback wrong");
  a_mask_bits: assert property (wr_at(tas_pkg::ADDR_MASK) ##1 rd_at(tas_pkg::ADDR_MASK)
    |=> io_rdata == ($past(io_req.wdata, 2) & tas_pkg::FLAG_MASK)) else $error("mask readback");
endmodule

bind tas_timer16 tas_timer16_props i_props (.clk(clk), .srst(srst), .io_req(io_req),
  .io_rdata(io_rdata), .irq_req(irq_req), .prescaler_reset_t0(prescaler_reset_t0),
  .prescaler_reset_t1(prescaler_reset_t1), .count_at_floor(count_at_floor),
  .count_at_max(count_at_max));

//--- test/tas_cpu_model.sv
// CPU core model issuing byte accesses on the timer I/O bus
module tas_cpu_model (
  input  wire logic               clk,
  output tas_pkg::tas_io_req_type io_req,
  input  wire logic [7:0]         io_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial io_req = '0;
  // One byte access: launched at the falling edge, answer taken after the rising edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk);
    io_req = '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clk);
    #1 q = io_rdata;
  endtask
  // Released bus shows inverted lines, so no stale value looks valid
  task automatic idle();
    @(negedge clk);
    io_req = '{addr: ~io_req.addr, wr: 1'b0, rd: 1'b0, wdata: ~io_req.wdata};
  endtask
  // Word write, high byte first; caller must follow with an access or idle
  task automatic wr16(input logic [7:0] al, input logic [15:0] v);
    logic [7:0] q;
    acc(1'b1, al + 8'h01, v[15:8], q);
    acc(1'b1, al, v[7:0], q);
  endtask
  // Word read, low byte first so the high byte comes from the temporary
  task automatic rd16(input logic [7:0] al, output logic [15:0] v);
    acc(1'b0, al, 8'h00, v[7:0]);
    acc(1'b0, al + 8'h01, 8'h00, v[15:8]);
    idle();
  endtask
endmodule

//--- test/tb.sv
// Self-checking bench for the 16-bit timer access front end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk = 1'b0;
  logic                    srst = 1'b1;
  tas_pkg::tas_io_req_type io_req;
  logic [7:0]              io_rdata;
  logic [3:0]              irq_req;
  logic                    psr_t0;
  logic                    psr_t1;
  logic [3:0]              oc_a;
  logic [3:0]              oc_b;
  logic                    cap_pin = 1'b0;
  int                      error_cnt = 0;
  int                      compares = 0;
  logic [15:0]             w;
  logic [7:0]              b;
  // Free-running system clock
  always #5 clk = ~clk;
  tas_cpu_model i_cpu (.clk(clk), .io_req(io_req), .io_rdata(io_rdata));
  // Count pin and comparator held quiet; the capture pin is driven by its scenario
  tas_timer16 i_dut (.clk(clk), .srst(srst), .io_req(io_req), .io_rdata(io_rdata),
    .irq_ack(4'h0), .irq_req(irq_req), .external_count_pin(1'b0), .capture_input_pin(cap_pin),
    .comparator_out(1'b0), .oc_pins_a(oc_a), .oc_pins_b(oc_b), .prescaler_reset_t0(psr_t0),
    .prescaler_reset_t1(psr_t1), .count_at_floor(), .count_at_max());
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    i_cpu.acc(1'b1, a, d, b);
    i_cpu.idle();
  endtask
  task automatic rd8(input logic [7:0] a);
    i_cpu.acc(1'b0, a, 8'h00, b);
    i_cpu.idle();
  endtask
  task automatic t_sync();
    chk({psr_t0, psr_t1}, 2'b00);
    wr8(tas_pkg::ADDR_SYNC, 8'h83);
    repeat (3) @(negedge clk);
    chk({psr_t0, psr_t1}, 2'b11);
    rd8(tas_pkg::ADDR_SYNC);
    chk(b, 8'h83);
    wr8(tas_pkg::ADDR_SYNC, 8'h00);
    chk({psr_t0, psr_t1}, 2'b00);
    wr8(tas_pkg::ADDR_SYNC, 8'h01);
    chk(psr_t1, 1'b1);
    @(negedge clk);
    chk(psr_t1, 1'b0);
    $display("t_sync done");
  endtask
  task automatic t_word();
    i_cpu.wr16(tas_pkg::ADDR_CNT_L, 16'h1234);
    i_cpu.rd16(tas_pkg::ADDR_CNT_L, w);
    chk(w, 16'h1234);
    wr8(tas_pkg::ADDR_CNT_H, 8'h55);
    i_cpu.rd16(tas_pkg::ADDR_CNT_L, w);
    chk(w, 16'h1234);
    wr8(tas_pkg::ADDR_CMPA_H, 8'hAB);
    wr8(tas_pkg::ADDR_CNT_L, 8'h00);
    i_cpu.wr16(tas_pkg::ADDR_CMPA_L, 16'h5678);
    rd8(tas_pkg::ADDR_CMPA_H);
    rd8(tas_pkg::ADDR_CNT_L);
    rd8(tas_pkg::ADDR_CMPA_H);
    chk(b, 8'h56);
    rd8(tas_pkg::ADDR_CNT_H);
    chk(b, 8'hAB);
    i_cpu.acc(1'b1, tas_pkg::ADDR_CTRL_B, 8'hC0, b);
    i_cpu.acc(1'b0, tas_pkg::ADDR_CTRL_B, 8'h00, b);
    i_cpu.idle();
    chk(b, 8'hC0);
    $display("t_word done");
  endtask
  task automatic t_count();
    i_cpu.wr16(tas_pkg::ADDR_CNT_L, 16'h0000);
    i_cpu.wr16(tas_pkg::ADDR_CNT_L, 16'hFFFF);
    i_cpu.acc(1'b1, tas_pkg::ADDR_CTRL_B, 8'h00, b);
    i_cpu.rd16(tas_pkg::ADDR_CNT_L, w);
    chk(w, 16'hFFFF);
    i_cpu.acc(1'b1, tas_pkg::ADDR_MASK, 8'hFF, b);
    i_cpu.acc(1'b0, tas_pkg::ADDR_MASK, 8'h00, b);
    i_cpu.acc(1'b1, tas_pkg::ADDR_CTRL_B, {5'h00, tas_pkg::CS_SYS}, b);
    wr8(tas_pkg::ADDR_CTRL_B, 8'h00);
    rd8(tas_pkg::ADDR_FLAG);
    chk(b & 8'h01, 8'h01);
    chk(irq_req[0], 1'b1);
    wr8(tas_pkg::ADDR_FLAG, 8'h0F);
    @(negedge clk);
    chk(irq_req, 4'h0);
    $display("t_count done");
  endtask
  // One system tick with counter on compare B: flag, request and enabled pins follow
  task automatic t_match();
    i_cpu.wr16(tas_pkg::ADDR_CMPB_L, 16'h0100);
    i_cpu.wr16(tas_pkg::ADDR_CNT_L, 16'h0100);
    wr8(tas_pkg::ADDR_OUT_EN, 8'hA5);
    i_cpu.acc(1'b1, tas_pkg::ADDR_CTRL_B, {5'h00, tas_pkg::CS_SYS}, b);
    wr8(tas_pkg::ADDR_CTRL_B, 8'h00);
    rd8(tas_pkg::ADDR_FLAG);
    chk(b, 8'h04);
    chk(irq_req, 4'h4);
    chk({oc_b, oc_a}, 8'hA0);
    $display("t_match done");
  endtask
  // Rising capture pin edge, filter off, snapshots the stopped counter
  task automatic t_cap();
    i_cpu.wr16(tas_pkg::ADDR_CNT_L, 16'h0321);
    wr8(tas_pkg::ADDR_CTRL_B, 8'h40);
    cap_pin = 1'b1;
    repeat (6) @(negedge clk);
    i_cpu.rd16(tas_pkg::ADDR_CAP_L, w);
    chk(w, 16'h0321);
    rd8(tas_pkg::ADDR_FLAG);
    chk(b & 8'h08, 8'h08);
    $display("t_cap done");
  endtask
  // Verdict and end of run
  task automatic results();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    t_sync();
    t_word();
    t_count();
    t_match();
    t_cap();
    results();
  end
  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule
